//--- core/pin_sync.sv
// Three-stage synchroniser with agreement filter for outside signals
`timescale 1ns/100ps
`default_nettype none
module pin_sync
	import sar_readout_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] mid_r;
	logic [WIDTH-1:0] last_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] level_nxt;

	// ----------------------------------------------------------------
	// Filter
	// ----------------------------------------------------------------
	// A bit counts as changed only when stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			level_nxt[i] = (mid_r[i] == last_r[i]) ? last_r[i] : level_r[i];
		end
	end

	// Stage one feeds stage two only
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= '0;
			mid_r <= '0;
			last_r <= '0;
			level_r <= '0;
		end else begin
			meta_r <= i_async;
			mid_r <= meta_r;
			last_r <= mid_r;
			level_r <= level_nxt;
		end
	end

	assign o_level = level_r;

endmodule
`default_nettype wire

//--- core/sar_adc_serial_readout.sv
// Conversion start, mode selection and serial result readout
`timescale 1ns/100ps
`default_nettype none
module sar_adc_serial_readout
	import sar_readout_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_serial_clk,
	input wire logic i_conversion_start_in,
	input wire logic i_select_or_chain_input,
	input wire logic [15:0] i_sample_code,
	output logic o_result_serial_out,
	output logic o_result_serial_out_oe,
	output logic o_chain_mode
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_core_n;

	// Two flops give the whole core domain one clean release edge
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_core_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_core_n <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisation and serial clock crossing
	// ----------------------------------------------------------------
	logic [2:0] pins_raw;
	logic [2:0] pins_level;
	pin_group_type pins;
	logic [2:0] wr_gray;
	logic [2:0] wr_gray_core;
	logic [3:0] ring;

	assign pins_raw = {i_conversion_start_in, i_select_or_chain_input,
		i_serial_clk};
	assign pins = pin_group_type'(pins_level);

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_core_n),
		.i_async(pins_raw),
		.o_level(pins_level)
	);

	// Falling edges are counted on the serial clock itself
	sck_capture u_sck_capture (
		.i_sck(i_serial_clk),
		.i_rst_n(i_rst_n),
		.i_chain_in(i_select_or_chain_input),
		.o_wr_gray(wr_gray),
		.o_ring(ring)
	);

	// Gray pointer changes one bit at a time, so the filter is safe on it
	pin_sync #(
		.WIDTH(PTR_BITS)
	) u_ptr_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_core_n),
		.i_async(wr_gray),
		.o_level(wr_gray_core)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	rd_state_type state_r;
	rd_state_type state_nxt;
	logic chain_r;
	logic chain_nxt;
	logic busy_r;
	logic busy_nxt;
	logic first_r;
	logic first_nxt;
	logic [15:0] shift_r;
	logic [15:0] shift_nxt;
	logic [4:0] count_r;
	logic [4:0] count_nxt;
	logic [7:0] timer_r;
	logic [7:0] timer_nxt;
	logic [2:0] rd_ptr_r;
	logic [2:0] rd_ptr_nxt;
	logic start_prev_r;
	logic select_prev_r;
	sdo_drive_type out_r;
	sdo_drive_type out_nxt;
	// Pin history and the hold-off after reset
	logic start_prev_nxt;
	logic select_prev_nxt;
	logic [5:0] settle_r;
	logic [5:0] settle_nxt;
	logic pins_ready;

	logic start_rise;
	logic select_rise;
	logic both_low;
	logic edge_avail;
	logic edge_bit;
	logic [4:0] edge_limit;
	logic [4:0] count_inc;

	// ----------------------------------------------------------------
	// Pin settling after reset
	// ----------------------------------------------------------------
	// Filtered levels start at zero, which reads as start and select
	// both low and would drive the output by mistake; events and the
	// chain drive wait until the levels and their history are real.
	// Six cycles cover the filter stages plus one for the history.
	always_comb begin
		settle_nxt = {settle_r[4:0], 1'b1};
		start_prev_nxt = pins.conv_start;
		select_prev_nxt = pins.sel_chain;
	end

	always_ff @(posedge i_core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			settle_r <= 6'h00;
		end else begin
			settle_r <= settle_nxt;
		end
	end

	assign pins_ready = settle_r[5];

	// Events seen on the filtered pin levels
	assign start_rise = pins_ready & pins.conv_start & ~start_prev_r;
	assign select_rise = pins_ready & pins.sel_chain & ~select_prev_r;
	assign both_low = pins_ready & ~pins.conv_start & ~pins.sel_chain;
	assign edge_avail = (gray_to_bin(wr_gray_core) != rd_ptr_r);
	assign edge_bit = ring[rd_ptr_r[1:0]];
	assign edge_limit = busy_r ? EDGES_WITH_BUSY : EDGES_NO_BUSY;
	assign count_inc = count_r + 5'h01;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A start edge wins over every state; the ring is drained one edge a
	// cycle, and edges outside a read are dropped so none is seen stale.
	// The ring holds four edges, so a burst must leave time to drain.
	always_comb begin
		state_nxt = state_r;
		chain_nxt = chain_r;
		busy_nxt = busy_r;
		first_nxt = first_r;
		shift_nxt = shift_r;
		count_nxt = count_r;
		timer_nxt = timer_r;
		out_nxt = out_r;
		rd_ptr_nxt = edge_avail ? (rd_ptr_r + 3'h1) : rd_ptr_r;
		if (start_rise) begin
			shift_nxt = i_sample_code;
			chain_nxt = ~pins.sel_chain;
			busy_nxt = pins.sck_level;
			timer_nxt = CONV_LOAD;
			out_nxt = '{oe: 1'b0, data: 1'b0};
			state_nxt = ST_CONVERT;
		end else begin
			case (state_r)
				ST_CONVERT: begin
					// Runs on the core clock only, whatever select or clock do
					if (timer_r != TIMER_RESET) begin
						timer_nxt = timer_r - 8'h01;
					end else if (chain_r) begin
						count_nxt = EDGE_COUNT_RESET;
						state_nxt = ST_SHIFT;
						if (busy_r) begin
							first_nxt = 1'b1;
							out_nxt = '{oe: 1'b1, data: 1'b1};
						end else begin
							first_nxt = 1'b0;
							out_nxt = '{oe: 1'b1, data: shift_r[15]};
						end
					end else if (!pins.conv_start) begin
						busy_nxt = 1'b1;
						first_nxt = 1'b1;
						count_nxt = EDGE_COUNT_RESET;
						out_nxt = '{oe: 1'b1, data: 1'b0};
						state_nxt = ST_SHIFT;
					end else begin
						busy_nxt = 1'b0;
						state_nxt = ST_WAIT_SELECT;
					end
				end
				ST_WAIT_SELECT: begin
					// Output leaves high impedance once selected
					if (!pins.sel_chain) begin
						first_nxt = 1'b0;
						count_nxt = EDGE_COUNT_RESET;
						out_nxt = '{oe: 1'b1, data: shift_r[15]};
						state_nxt = ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					// Select rise ends a 4-wire read at once, even mid-bit
					if (!chain_r && select_rise) begin
						out_nxt = '{oe: 1'b0, data: 1'b0};
						state_nxt = ST_RELEASED;
					end else if (!chain_r && edge_avail &&
						(count_inc == edge_limit)) begin
						count_nxt = count_inc;
						out_nxt = '{oe: 1'b0, data: 1'b0};
						state_nxt = ST_RELEASED;
					end else if (edge_avail) begin
						count_nxt = count_inc;
						if (first_r) begin
							// Busy bit done: own MSB next, upstream busy dropped
							first_nxt = 1'b0;
							out_nxt.data = shift_r[15];
						end else begin
							// Chain fills from upstream, 4-wire fills with zero
							shift_nxt = {shift_r[14:0], chain_r & edge_bit};
							out_nxt.data = shift_r[14];
						end
					end
					if (chain_r && both_low) begin
						out_nxt = '{oe: 1'b1, data: 1'b0};
					end
				end
				default: begin
					// Idle or released: only the chain pull-down drives
					out_nxt = '{oe: both_low, data: 1'b0};
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Only registers here; every next value comes from the logic above
	always_ff @(posedge i_core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state_r <= ST_IDLE;
			chain_r <= 1'b0;
			busy_r <= 1'b0;
			first_r <= 1'b0;
			shift_r <= RESULT_RESET;
			count_r <= EDGE_COUNT_RESET;
			timer_r <= TIMER_RESET;
			rd_ptr_r <= PTR_RESET;
			start_prev_r <= 1'b0;
			select_prev_r <= 1'b0;
			out_r <= '{oe: 1'b0, data: 1'b0};
		end else begin
			state_r <= state_nxt;
			chain_r <= chain_nxt;
			busy_r <= busy_nxt;
			first_r <= first_nxt;
			shift_r <= shift_nxt;
			count_r <= count_nxt;
			timer_r <= timer_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			start_prev_r <= start_prev_nxt;
			select_prev_r <= select_prev_nxt;
			out_r <= out_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign o_result_serial_out = out_r.data;
	assign o_result_serial_out_oe = out_r.oe;
	assign o_chain_mode = chain_r;

endmodule
`default_nettype wire

//--- core/sar_readout_pkg.sv
// Shared constants, types and helpers of the serial readout block
package sar_readout_pkg;

	// ----------------------------------------------------------------
	// Result format and frame lengths
	// ----------------------------------------------------------------
	localparam int RESULT_BITS = 16;
	// Two's complement code: +full 16'h7fff, -full 16'h8000, mid 16'h0000
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [4:0] EDGES_NO_BUSY = 5'h10;
	localparam logic [4:0] EDGES_WITH_BUSY = 5'h11;
	localparam logic [4:0] EDGE_COUNT_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Conversion timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_HZ = 25000000;
	// Conversion time, plain default
	localparam int CONV_TIME_NS = 1000;
	// Longest time: rounded down to whole core cycles, at least one
	localparam int CONV_CYCLES_RAW =
		(CONV_TIME_NS * (CORE_CLK_HZ / 1000000)) / 1000;
	localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
	localparam logic [7:0] CONV_LOAD = 8'(CONV_CYCLES - 1);
	localparam logic [7:0] TIMER_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Edge pointer between the serial clock and the core clock
	// ----------------------------------------------------------------
	localparam int PTR_BITS = 3;
	localparam logic [2:0] PTR_RESET = 3'h0;
	localparam logic [3:0] RING_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CONVERT = 3'b001,
		ST_WAIT_SELECT = 3'b010,
		ST_SHIFT = 3'b011,
		ST_RELEASED = 3'b100
	} rd_state_type;

	typedef struct packed {
		logic conv_start;
		logic sel_chain;
		logic sck_level;
	} pin_group_type;

	typedef struct packed {
		logic oe;
		logic data;
	} sdo_drive_type;

	localparam logic [2:0] PINS_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Gray code helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] bin_to_gray(input logic [2:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [2:0] gray_to_bin(input logic [2:0] g);
		logic [2:0] b;
		b[2] = g[2];
		b[1] = g[1] ^ b[2];
		b[0] = g[0] ^ b[1];
		return b;
	endfunction

endpackage

//--- core/sck_capture.sv
// Serial clock domain: counts falling edges and keeps the input bits
`timescale 1ns/100ps
`default_nettype none
module sck_capture
	import sar_readout_pkg::*;
(
	input wire logic i_sck,
	input wire logic i_rst_n,
	input wire logic i_chain_in,
	output logic [2:0] o_wr_gray,
	output logic [3:0] o_ring
);

	logic rst_meta_r;
	logic rst_sync_r;
	logic [2:0] wr_bin_r;
	logic [2:0] wr_bin_nxt;
	logic [2:0] wr_gray_r;
	logic [2:0] wr_gray_nxt;
	logic [3:0] ring_r;
	logic [3:0] ring_nxt;

	// ----------------------------------------------------------------
	// Local reset release
	// ----------------------------------------------------------------
	// The serial clock may stand still, so reset only releases on its edges
	always_ff @(negedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Edge ring
	// ----------------------------------------------------------------
	// Each falling edge stores the input bit and advances the pointer
	always_comb begin
		wr_bin_nxt = wr_bin_r + 3'h1;
		wr_gray_nxt = bin_to_gray(wr_bin_nxt);
		ring_nxt = ring_r;
		ring_nxt[wr_bin_r[1:0]] = i_chain_in;
	end

	always_ff @(negedge i_sck or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			wr_bin_r <= PTR_RESET;
			wr_gray_r <= PTR_RESET;
			ring_r <= RING_RESET;
		end else begin
			wr_bin_r <= wr_bin_nxt;
			wr_gray_r <= wr_gray_nxt;
			ring_r <= ring_nxt;
		end
	end

	assign o_wr_gray = wr_gray_r;
	assign o_ring = ring_r;

endmodule
`default_nettype wire

//--- testbench/sar_host_model.sv
// Host side model: serial clock bursts, pull-up and upstream bits
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
	input wire logic i_sdo,
	input wire logic i_sdo_oe,
	output logic o_sck,
	output logic o_chain
);
	// Pull-up holds the line high while the converter lets go
	wire line = i_sdo_oe ? i_sdo : 1'b1;
	// ----------------------------------------------------------------
	// Clock and data
	// ----------------------------------------------------------------
	// Clock stands still between frames, low unless set_sck holds it high
	initial begin
		o_sck = 1'b0;
		o_chain = 1'b0;
	end
	// Clock level at a start rise picks the busy option in chain mode
	task automatic set_sck(input logic v);
		o_sck = v;
	endtask
	// 40 ns pulses 400 ns apart: the output lags each fall by up to 200 ns
	task automatic burst(input int n, input logic [63:0] up,
		output logic [63:0] q);
		q = '0;
		for (int i = 0; i < n; i++) begin
			o_chain = up[n-1-i];
			#40 o_sck = 1'b1;
			q = {q[62:0], line};
			#40 o_sck = 1'b0;
			#320;
		end
		o_chain = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- testbench/sar_readout_asserts.sv
// Port-level checker of the serial readout block
`timescale 1ns/100ps
`default_nettype none
module sar_readout_asserts (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_serial_clk,
	input wire logic i_conversion_start_in,
	input wire logic i_select_or_chain_input,
	input wire logic [15:0] i_sample_code,
	input wire logic o_result_serial_out,
	input wire logic o_result_serial_out_oe,
	input wire logic o_chain_mode
);
	// Short aliases keep each property on one line
	wire st = i_conversion_start_in;
	wire sl = i_select_or_chain_input;
	wire oe = o_result_serial_out_oe;
	wire d = o_result_serial_out;
	wire cm = o_chain_mode;
	wire msb = i_sample_code[15];
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// Pin changes are seen 3-4 edges late, so windows start a few edges on
	start_hiz_a: assert property ($rose(st) |-> ##[1:6] (!oe) [*8])
		else $error("output kept driven after start");
	chain_pick_a: assert property ($rose(st) && !sl |-> ##[3:8] cm)
		else $error("chain mode not chosen");
	both_low_a: assert property ((!st && !sl) [*7] |-> oe && !d)
		else $error("output not driven low");
	sel_release_a: assert property ($rose(sl) && !cm |-> ##[2:7] !oe)
		else $error("output kept after select rise");
	bit_hold_a: assert property (
		i_serial_clk && oe && $past(oe) |-> $stable(d))
		else $error("bit changed while clock high");
	chain_eoc_a: assert property (
		$rose(st) && !sl && !i_serial_clk |-> ##[27:36] (oe && d == msb))
		else $error("chain result msb missing");
	busy_eoc_a: assert property (
		$rose(st) && !sl && i_serial_clk |-> ##[27:36] (oe && d))
		else $error("chain busy bit missing");
	cs_msb_a: assert property ($rose(oe) && !cm && !sl |-> d == msb)
		else $error("select read does not start with msb");
endmodule
bind sar_adc_serial_readout sar_readout_asserts sar_readout_asserts_inst (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_serial_clk(i_serial_clk),
	.i_conversion_start_in(i_conversion_start_in),
	.i_select_or_chain_input(i_select_or_chain_input),
	.i_sample_code(i_sample_code),
	.o_result_serial_out(o_result_serial_out),
	.o_result_serial_out_oe(o_result_serial_out_oe),
	.o_chain_mode(o_chain_mode));
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the serial readout block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n, start, sel_r, chain_en, sck, host_chain;
	logic result_serial_out, sdo_oe, chain_mode;
	logic [15:0] code;
	logic [63:0] q;
	int fail_count, checks_done;
	wire sel = chain_en ? host_chain : sel_r;
	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	always #20 core_clk = ~core_clk;
	sar_adc_serial_readout sar_adc_serial_readout_inst (
		.i_core_clk(core_clk), .i_rst_n(rst_n), .i_serial_clk(sck),
		.i_conversion_start_in(start), .i_select_or_chain_input(sel),
		.i_sample_code(code), .o_result_serial_out(result_serial_out),
		.o_result_serial_out_oe(sdo_oe), .o_chain_mode(chain_mode));
	sar_host_model sar_host_model_inst (.i_sdo(result_serial_out), .i_sdo_oe(sdo_oe),
		.o_sck(sck), .o_chain(host_chain));
	// Shared compare, wait and report helpers
	task check(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task wait_oe(input logic v, input int n);
		int k;
		k = 0;
		while (sdo_oe !== v && k < n) begin
			@(negedge core_clk);
			k++;
		end
		check(sdo_oe, v);
		if (sdo_oe !== v) summarize();
	endtask
	task summarize();
		$display("checks=%0d mismatches=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Select read without busy bit, full length
	task cs_plain();
		code = 16'h8000;
		start = 1'b1;
		idle(7);
		check(sdo_oe, 1'b0);
		check(chain_mode, 1'b0);
		idle(40);
		check(sdo_oe, 1'b0);
		sel_r = 1'b0;
		wait_oe(1'b1, 12);
		sar_host_model_inst.burst(16, 64'h0, q);
		check(q[15:0], code);
		check(sdo_oe, 1'b0);
		sel_r = 1'b1;
		start = 1'b0;
		idle(8);
	endtask
	// Select dropped mid-conversion, read cut short by select rise
	task cs_early();
		code = 16'h35ac;
		start = 1'b1;
		idle(8);
		sel_r = 1'b0;
		wait_oe(1'b1, 40);
		sar_host_model_inst.burst(5, 64'h0, q);
		check(q[4:0], code[15:11]);
		sel_r = 1'b1;
		wait_oe(1'b0, 8);
		start = 1'b0;
		idle(8);
	endtask
	// Select mode with busy bit: start low before conversion ends
	task cs_busy();
		code = 16'h7fff;
		start = 1'b1;
		idle(8);
		start = 1'b0;
		wait_oe(1'b1, 40);
		check(result_serial_out, 1'b0);
		sar_host_model_inst.burst(17, 64'h0, q);
		check(q[16:0], {1'b0, code});
		check(sdo_oe, 1'b0);
	endtask
	// Chain without busy bit, upstream word forwarded after own bits
	task chain_plain();
		chain_en = 1'b1;
		idle(8);
		check({sdo_oe, result_serial_out}, 2'b10);
		code = 16'ha5c3;
		start = 1'b1;
		idle(7);
		check(chain_mode, 1'b1);
		wait_oe(1'b1, 40);
		check(result_serial_out, code[15]);
		sar_host_model_inst.burst(32, {16'h3c96, 16'h0000}, q);
		check(q[31:0], {code, 16'h3c96});
		start = 1'b0;
	endtask
	// Chain with busy bit; a clock fall mid-conversion is ignored
	task chain_busy();
		idle(8);
		check({sdo_oe, result_serial_out}, 2'b10);
		code = 16'h5a0f;
		sar_host_model_inst.set_sck(1'b1);
		start = 1'b1;
		idle(8);
		sar_host_model_inst.set_sck(1'b0);
		wait_oe(1'b1, 40);
		check(result_serial_out, 1'b1);
		sar_host_model_inst.burst(33, {1'b1, 16'hc3a5, 16'h0000}, q);
		check(q[32:0], {1'b1, code, 16'hc3a5});
		start = 1'b0;
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		sel_r = 1'b1;
		chain_en = 1'b0;
		code = 16'h0000;
		fail_count = 0;
		checks_done = 0;
		idle(5);
		rst_n = 1'b1;
		idle(10);
		// Two serial falls release the edge counter's own reset
		sar_host_model_inst.burst(2, 64'h0, q);
		cs_plain();
		cs_early();
		cs_busy();
		chain_plain();
		chain_busy();
		summarize();
	end
endmodule
`default_nettype wire
